// file: logic/ccr_map.svh
// register map, field positions and reset values of the clock and reset controller
// Functional notes
// - memory register: arbiter reset 13, controller 12
// - run bit per clock, plus a dynamic gating bit on all but three clocks
// - display resets at 12, enables 7,5,3,1
// - card reset 12, two enable/gating pairs
// - image resets 13/12, bit 5 sensor clock
// - still codec reset 12, two pairs
// - 3D resets 13/12, enables 5,3,1
// - 2D resets 13/12, enables 5,3,1
// - video resets 13/12, six pairs below
// - microprocessor reset 12, bit 5 timer clock
// - bit 14 picks timer source crystal/PLL
// - system timer reset, run, system clock bits
// - bit 10 picks divider source PLL/crystal
// - capture source pixel/sensor, normal or inverted
// - bits 7:0 enable divider groups
// - 7-bit audio master ratio, image divider enable
// - five 2-bit ratios divide by 1..4
// - regfile pulse delay 0.5 ns steps
// - four 8-bit ratios divide by N+1
// - capture delay: four 4-bit delay cells
// - 12-bit audio ratio, 4-bit output ratio
// - 5-bit image ratio in bits 15:11
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CCR_OFF_MEM 9'h012
`define CCR_OFF_DISP 9'h014
`define CCR_OFF_CARD 9'h016
`define CCR_OFF_IMG 9'h018
`define CCR_OFF_STILL 9'h01a
`define CCR_OFF_THREED 9'h01c
`define CCR_OFF_TWOD 9'h01e
`define CCR_OFF_VIDEO 9'h024
`define CCR_OFF_MICRO 9'h026
`define CCR_OFF_DIVSRC 9'h030
`define CCR_OFF_AUX 9'h032
`define CCR_OFF_SMALL 9'h034
`define CCR_OFF_DRATIO 9'h036
`define CCR_OFF_SRATIO 9'h038
`define CCR_OFF_CAPDLY 9'h03a
`define CCR_OFF_AUDIO 9'h03c
`define CCR_OFF_IRATIO 9'h03e

// ----------------------------------------
// reset values and implemented-bit masks
// ----------------------------------------
`define CCR_RST_ZERO 16'h0000
`define CCR_RST_DIVSRC 16'h1801
`define CCR_RST_SMALL 16'h8000
`define CCR_MSK_MEM 16'h300f
`define CCR_MSK_DISP 16'h10ff
`define CCR_MSK_CARD 16'h100f
`define CCR_MSK_IMG 16'h33ff
`define CCR_MSK_STILL 16'h100f
`define CCR_MSK_THREED 16'h303f
`define CCR_MSK_TWOD 16'h303f
`define CCR_MSK_VIDEO 16'h3fff
`define CCR_MSK_MICRO 16'h13ef
`define CCR_MSK_DIVSRC 16'h7fff
`define CCR_MSK_AUX 16'h7f1f
`define CCR_MSK_SMALL 16'hf3ff
`define CCR_MSK_FULL 16'hffff
`define CCR_MSK_IRATIO 16'hf800

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCR_BIT_RST_HI 13
`define CCR_BIT_RST_LO 12
`define CCR_BIT_TIMER_SRC 14
`define CCR_BIT_SYS_TIMER_RST 13
`define CCR_BIT_SYS_TIMER_EN 12
`define CCR_BIT_SYS_CLK_EN 11
`define CCR_BIT_USE_CRYSTAL 10
`define CCR_BIT_TIMER_CLK_EN 5

// ----------------------------------------
// delay cell step, in picoseconds
// ----------------------------------------
`define CCR_DELAY_STEP_PS 500

`endif

// file: logic/ccr_pkg.sv
// shared types of the clock and reset controller
package ccr_pkg;
  typedef logic [15:0] ccr_word_t;
  typedef logic [11:0] ccr_ratio_t;
  typedef enum logic [1:0] {
    CCR_CAP_PIXEL = 2'h0,
    CCR_CAP_PIXEL_INV = 2'h1,
    CCR_CAP_SENSOR = 2'h2,
    CCR_CAP_SENSOR_INV = 2'h3
  } ccr_cap_src_t;
endpackage

// file: logic/ccr_div_if.sv
// link between the controller and one clock divider
`timescale 1ns/1ps
interface ccr_div_if;
  ccr_pkg::ccr_ratio_t ratio;
  logic enable;
  logic srcTick;
  logic tick;
  modport ctrl (output ratio, output enable, output srcTick, input tick);
  modport div (input ratio, input enable, input srcTick, output tick);
endinterface

// file: logic/ccr_clock_divider.sv
// divide-by-N+1 tick generator with ratio taken at a period boundary or while disabled
`timescale 1ns/1ps
module ccr_clock_divider (
  input wire logic sys_clk,
  input wire logic rst_b,
  ccr_div_if.div bus
);
  import ccr_pkg::*;

  ccr_ratio_t countQ;
  ccr_ratio_t countD;
  ccr_ratio_t ratioQ;
  ccr_ratio_t ratioD;
  logic tickQ;
  logic tickD;
  logic wrap;

  // a new ratio is adopted at wrap or while disabled, so no period is ever cut short
  assign wrap = (countQ >= ratioQ);

  // next-state of the counter
  always_comb begin
    countD = countQ;
    ratioD = ratioQ;
    tickD = 1'b0;
    if (!bus.enable) begin
      countD = '0;
      ratioD = bus.ratio;
    end else if (bus.srcTick) begin
      if (wrap) begin
        countD = '0;
        ratioD = bus.ratio;
        tickD = 1'b1;
      end else begin
        countD = countQ + 12'h001;
      end
    end
  end

  // state registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      countQ <= '0;
      ratioQ <= '0;
      tickQ <= 1'b0;
    end else begin
      countQ <= countD;
      ratioQ <= ratioD;
      tickQ <= tickD;
    end
  end

  assign bus.tick = tickQ;
endmodule

// file: logic/ccr_top.sv
// module clock enables, soft resets, dividers and clock source control
`timescale 1ns/1ps
`include "ccr_map.svh"
module ccr_top (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [8:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire ccr_pkg::ccr_word_t regWdata,
  output ccr_pkg::ccr_word_t regRdataQ,
  input wire logic crystalTick,
  input wire logic pllTick,
  input wire logic pixelClkPin,
  input wire logic [31:0] moduleIdle,
  output logic [13:0] moduleResetQ,
  output logic [31:0] moduleClkEnQ,
  output logic [12:0] divTick,
  output logic timerTickQ,
  output logic sysTimerResetQ,
  output logic sysTimerRunQ,
  output logic sysClkEnQ,
  output logic captureClkQ,
  output logic [3:0] regfilePulseDelayQ,
  output logic [15:0] captureDelayQ
);
  import ccr_pkg::*;

  // ----------------------------------------
  // register table
  // ----------------------------------------
  localparam int REG_COUNT = 17;
  localparam int DIV_COUNT = 13;

  localparam logic [8:0] REG_OFF [REG_COUNT] = '{
    `CCR_OFF_MEM, `CCR_OFF_DISP, `CCR_OFF_CARD, `CCR_OFF_IMG,
    `CCR_OFF_STILL, `CCR_OFF_THREED, `CCR_OFF_TWOD, `CCR_OFF_VIDEO,
    `CCR_OFF_MICRO, `CCR_OFF_DIVSRC, `CCR_OFF_AUX, `CCR_OFF_SMALL,
    `CCR_OFF_DRATIO, `CCR_OFF_SRATIO, `CCR_OFF_CAPDLY, `CCR_OFF_AUDIO,
    `CCR_OFF_IRATIO
  };

  localparam ccr_word_t REG_RST [REG_COUNT] = '{
    `CCR_RST_ZERO, `CCR_RST_ZERO, `CCR_RST_ZERO, `CCR_RST_ZERO,
    `CCR_RST_ZERO, `CCR_RST_ZERO, `CCR_RST_ZERO, `CCR_RST_ZERO,
    `CCR_RST_ZERO, `CCR_RST_DIVSRC, `CCR_RST_ZERO, `CCR_RST_SMALL,
    `CCR_RST_ZERO, `CCR_RST_ZERO, `CCR_RST_ZERO, `CCR_RST_ZERO,
    `CCR_RST_ZERO
  };

  // reserved bits never store, so they read back as zero
  localparam ccr_word_t REG_MSK [REG_COUNT] = '{
    `CCR_MSK_MEM, `CCR_MSK_DISP, `CCR_MSK_CARD, `CCR_MSK_IMG,
    `CCR_MSK_STILL, `CCR_MSK_THREED, `CCR_MSK_TWOD, `CCR_MSK_VIDEO,
    `CCR_MSK_MICRO, `CCR_MSK_DIVSRC, `CCR_MSK_AUX, `CCR_MSK_SMALL,
    `CCR_MSK_FULL, `CCR_MSK_FULL, `CCR_MSK_FULL, `CCR_MSK_FULL,
    `CCR_MSK_IRATIO
  };

  ccr_word_t regFileQ [REG_COUNT];
  logic regHit;
  logic [4:0] regIdx;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // an unmapped address matches nothing: writes drop, reads give zero
  always_comb begin
    regHit = 1'b0;
    regIdx = 5'h00;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (regAddr == REG_OFF[i]) begin
        regHit = 1'b1;
        regIdx = 5'(i);
      end
    end
  end

  // register storage, one word per index
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regFileQ[i] <= REG_RST[i];
      end
    end else if (regWrite && regHit) begin
      regFileQ[regIdx] <= regWdata & REG_MSK[regIdx];
    end
  end

  // read data lands one cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      regRdataQ <= '0;
    end else if (regRead && regHit) begin
      regRdataQ <= regFileQ[regIdx];
    end else begin
      regRdataQ <= '0;
    end
  end

  // ----------------------------------------
  // named views of the registers
  // ----------------------------------------
  ccr_word_t rMem;
  ccr_word_t rDisp;
  ccr_word_t rCard;
  ccr_word_t rImg;
  ccr_word_t rStill;
  ccr_word_t rThreeD;
  ccr_word_t rTwoD;
  ccr_word_t rVideo;
  ccr_word_t rMicro;
  ccr_word_t rDivSrc;
  ccr_word_t rAux;
  ccr_word_t rSmall;
  ccr_word_t rDRatio;
  ccr_word_t rSRatio;
  ccr_word_t rCapDly;
  ccr_word_t rAudio;
  ccr_word_t rIRatio;

  assign rMem = regFileQ[0];
  assign rDisp = regFileQ[1];
  assign rCard = regFileQ[2];
  assign rImg = regFileQ[3];
  assign rStill = regFileQ[4];
  assign rThreeD = regFileQ[5];
  assign rTwoD = regFileQ[6];
  assign rVideo = regFileQ[7];
  assign rMicro = regFileQ[8];
  assign rDivSrc = regFileQ[9];
  assign rAux = regFileQ[10];
  assign rSmall = regFileQ[11];
  assign rDRatio = regFileQ[12];
  assign rSRatio = regFileQ[13];
  assign rCapDly = regFileQ[14];
  assign rAudio = regFileQ[15];
  assign rIRatio = regFileQ[16];

  // ----------------------------------------
  // soft resets
  // ----------------------------------------
  logic [13:0] resetVec;

  // index 0 is the arbiter, 13 the image-side microprocessor
  assign resetVec = {
    rMicro[`CCR_BIT_RST_LO],
    rVideo[`CCR_BIT_RST_LO], rVideo[`CCR_BIT_RST_HI],
    rTwoD[`CCR_BIT_RST_LO], rTwoD[`CCR_BIT_RST_HI],
    rThreeD[`CCR_BIT_RST_LO], rThreeD[`CCR_BIT_RST_HI],
    rStill[`CCR_BIT_RST_LO],
    rImg[`CCR_BIT_RST_LO], rImg[`CCR_BIT_RST_HI],
    rCard[`CCR_BIT_RST_LO],
    rDisp[`CCR_BIT_RST_LO],
    rMem[`CCR_BIT_RST_LO], rMem[`CCR_BIT_RST_HI]
  };

  // ----------------------------------------
  // module clock run and gating bits
  // ----------------------------------------
  logic [31:0] runVec;
  logic [31:0] dgVec;
  logic [31:0] clkEnD;

  // slot 0 is the memory controller clock, slot 31 the isp-side cpu memory
  assign runVec = {
    rMicro[9], rMicro[7], rMicro[`CCR_BIT_TIMER_CLK_EN], rMicro[3], rMicro[1],
    rVideo[11], rVideo[9], rVideo[7], rVideo[5], rVideo[3], rVideo[1],
    rTwoD[5], rTwoD[3], rTwoD[1],
    rThreeD[5], rThreeD[3], rThreeD[1],
    rStill[3], rStill[1],
    rImg[9], rImg[7], rImg[5], rImg[3], rImg[1],
    rCard[3], rCard[1],
    rDisp[7], rDisp[5], rDisp[3], rDisp[1],
    rMem[3], rMem[1]
  };

  // clocks with no gating bit (display high, sensor, timer) never auto-gate
  assign dgVec = {
    rMicro[8], rMicro[6], 1'b0, rMicro[2], rMicro[0],
    rVideo[10], rVideo[8], rVideo[6], rVideo[4], rVideo[2], rVideo[0],
    rTwoD[4], rTwoD[2], rTwoD[0],
    rThreeD[4], rThreeD[2], rThreeD[0],
    rStill[2], rStill[0],
    rImg[8], rImg[6], 1'b0, rImg[2], rImg[0],
    rCard[2], rCard[0],
    rDisp[6], 1'b0, rDisp[2], rDisp[0],
    rMem[2], rMem[0]
  };

  // one gating term per module clock
  genvar s;
  generate
    for (s = 0; s < 32; s++) begin : g_gate
      assign clkEnD[s] = runVec[s] & ~(dgVec[s] & moduleIdle[s]);
    end
  endgenerate

  // enables leave through a flop so the gate cell never sees a glitch
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      moduleClkEnQ <= '0;
      moduleResetQ <= '0;
    end else begin
      moduleClkEnQ <= clkEnD;
      moduleResetQ <= resetVec;
    end
  end

  // ----------------------------------------
  // clock sources and system timer
  // ----------------------------------------
  logic dividersUseCrystal;
  logic timerClockSourceSel;
  logic srcTick;
  logic timerSrcTick;

  assign dividersUseCrystal = rDivSrc[`CCR_BIT_USE_CRYSTAL];
  assign srcTick = dividersUseCrystal ? crystalTick : pllTick;
  assign timerClockSourceSel = rDivSrc[`CCR_BIT_TIMER_SRC];
  assign timerSrcTick = timerClockSourceSel ? pllTick : crystalTick;

  // timer tick and system timer controls
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      timerTickQ <= 1'b0;
      sysTimerResetQ <= 1'b0;
      sysTimerRunQ <= 1'b0;
      sysClkEnQ <= 1'b0;
    end else begin
      timerTickQ <= timerSrcTick & rMicro[`CCR_BIT_TIMER_CLK_EN];
      sysTimerResetQ <= rDivSrc[`CCR_BIT_SYS_TIMER_RST];
      sysTimerRunQ <= rDivSrc[`CCR_BIT_SYS_TIMER_EN] & ~rDivSrc[`CCR_BIT_SYS_TIMER_RST];
      sysClkEnQ <= rDivSrc[`CCR_BIT_SYS_CLK_EN];
    end
  end

  // ----------------------------------------
  // dividers
  // ----------------------------------------
  ccr_ratio_t divRatio [DIV_COUNT];
  logic [12:0] divEn;

  // ratio fields, zero-extended; each divides by value plus one
  assign divRatio[0] = {10'h000, rSmall[9:8]};
  assign divRatio[1] = {10'h000, rSmall[7:6]};
  assign divRatio[2] = {10'h000, rSmall[5:4]};
  assign divRatio[3] = {10'h000, rSmall[3:2]};
  assign divRatio[4] = {10'h000, rSmall[1:0]};
  assign divRatio[5] = {4'h0, rDRatio[15:8]};
  assign divRatio[6] = {4'h0, rDRatio[7:0]};
  assign divRatio[7] = {4'h0, rSRatio[15:8]};
  assign divRatio[8] = {4'h0, rSRatio[7:0]};
  assign divRatio[9] = {5'h00, rAux[14:8]};
  assign divRatio[10] = rAudio[11:0];
  assign divRatio[11] = {8'h00, rAudio[15:12]};
  assign divRatio[12] = {7'h00, rIRatio[15:11]};

  // group enables; the bus clock divider follows the system clock enable
  assign divEn = {
    rAux[4],
    rAux[2], rAux[0], rAux[1],
    rDivSrc[7], rDivSrc[1], rDivSrc[3], rDivSrc[4],
    rDivSrc[`CCR_BIT_SYS_CLK_EN], rDivSrc[0], rDivSrc[2], rDivSrc[6], rDivSrc[5]
  };

  ccr_div_if divBus [DIV_COUNT] ();

  // one divider per generated clock, all fed from the common source
  genvar d;
  generate
    for (d = 0; d < DIV_COUNT; d++) begin : g_div
      assign divBus[d].ratio = divRatio[d];
      assign divBus[d].enable = divEn[d];
      assign divBus[d].srcTick = srcTick;
      assign divTick[d] = divBus[d].tick;
      ccr_clock_divider u_div (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .bus(divBus[d].div)
      );
    end
  endgenerate

  // ----------------------------------------
  // capture clock selection
  // ----------------------------------------
  logic pixSync1Q;
  logic pixSync2Q;
  logic pixSync3Q;
  logic pixelLevelQ;
  logic sensorLevelQ;
  ccr_cap_src_t captureSourceSel;
  logic captureD;

  assign captureSourceSel = ccr_cap_src_t'(rDivSrc[9:8]);

  // pixel clock pin is foreign: three flops, accepted when last two agree
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pixSync1Q <= 1'b0;
      pixSync2Q <= 1'b0;
      pixSync3Q <= 1'b0;
      pixelLevelQ <= 1'b0;
    end else begin
      pixSync1Q <= pixelClkPin;
      pixSync2Q <= pixSync1Q;
      pixSync3Q <= pixSync2Q;
      if (pixSync2Q == pixSync3Q) begin
        pixelLevelQ <= pixSync3Q;
      end
    end
  end

  // sensor clock level toggles on each sensor divider tick
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sensorLevelQ <= 1'b0;
    end else if (divTick[7]) begin
      sensorLevelQ <= ~sensorLevelQ;
    end
  end

  // source mux with optional inversion
  always_comb begin
    case (captureSourceSel)
      CCR_CAP_PIXEL: captureD = pixelLevelQ;
      CCR_CAP_PIXEL_INV: captureD = ~pixelLevelQ;
      CCR_CAP_SENSOR: captureD = sensorLevelQ;
      default: captureD = ~sensorLevelQ;
    endcase
  end

  // ----------------------------------------
  // capture output and delay codes
  // ----------------------------------------
  // the analog cells sit outside; each nibble counts 0.5 ns steps plus one
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      captureClkQ <= 1'b0;
      regfilePulseDelayQ <= '0;
      captureDelayQ <= '0;
    end else begin
      captureClkQ <= captureD;
      regfilePulseDelayQ <= rSmall[15:12];
      captureDelayQ <= rCapDly;
    end
  end
endmodule

// file: bench/ccr_top_checker.sv
// port-level property checker for the clock and reset controller
`timescale 1ns/1ps
`include "ccr_map.svh"
module ccr_top_checker (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [8:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire ccr_pkg::ccr_word_t regWdata,
  input wire ccr_pkg::ccr_word_t regRdataQ,
  input wire logic crystalTick,
  input wire logic pllTick,
  input wire logic [13:0] moduleResetQ,
  input wire logic [12:0] divTick,
  input wire logic timerTickQ,
  input wire logic sysTimerResetQ,
  input wire logic sysTimerRunQ,
  input wire logic sysClkEnQ,
  input wire logic [3:0] regfilePulseDelayQ,
  input wire logic [15:0] captureDelayQ
);
  import ccr_pkg::*;
  // ----------------------------------------
  // write decodes
  // ----------------------------------------
  // outputs lag a write by two edges: one to store, one to register out
  wire memWr = regWrite && regAddr == `CCR_OFF_MEM;
  wire cardWr = regWrite && regAddr == `CCR_OFF_CARD;
  wire divWr = regWrite && regAddr == `CCR_OFF_DIVSRC;
  wire smallWr = regWrite && regAddr == `CCR_OFF_SMALL;
  wire capWr = regWrite && regAddr == `CCR_OFF_CAPDLY;
  wire microWr = regWrite && regAddr == `CCR_OFF_MICRO;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // slot 0 is the arbiter at bit 13, slot 1 the memory controller at bit 12
  a_mem_soft_reset: assert property (memWr |-> ##2
    {moduleResetQ[0], moduleResetQ[1]} == $past(regWdata[13:12], 2))
    else $error("memory resets wrong");
  a_card_soft_reset: assert property (cardWr |-> ##2 moduleResetQ[3] == $past(regWdata[12], 2))
    else $error("card reset wrong");
  a_sys_timer_bits: assert property (divWr |-> ##2
    {sysTimerResetQ, sysClkEnQ} == $past({regWdata[13], regWdata[11]}, 2))
    else $error("system timer bits wrong");
  a_run_not_reset: assert property (divWr |-> ##2
    sysTimerRunQ == $past(regWdata[12] & ~regWdata[13], 2))
    else $error("timer run bit wrong");
  a_timer_tick_cause: assert property (timerTickQ |-> $past(crystalTick) || $past(pllTick))
    else $error("timer tick without source");
  a_div_tick_cause: assert property (divTick != 13'h0000 |-> $past(crystalTick) || $past(pllTick))
    else $error("divider tick without source");
  a_regfile_delay_code: assert property (smallWr |-> ##2 regfilePulseDelayQ == $past(regWdata[15:12], 2))
    else $error("regfile delay wrong");
  a_capture_delay_code: assert property (capWr |-> ##2 captureDelayQ == $past(regWdata, 2))
    else $error("capture delay wrong");
  a_micro_read_back: assert property (microWr ##1 !regWrite [*2] ##1
    (regRead && !regWrite && regAddr == `CCR_OFF_MICRO) |=> regRdataQ == ($past(regWdata, 4) & `CCR_MSK_MICRO))
    else $error("micro register read wrong");
  c_mem_reset: cover property (memWr ##2 moduleResetQ[0]);
  c_timer_tick: cover property (timerTickQ);
  c_image_div: cover property (divTick[12]);
endmodule
bind ccr_top ccr_top_checker chk (.sys_clk, .rst_b, .regAddr, .regWrite, .regRead, .regWdata, .regRdataQ,
  .crystalTick, .pllTick, .moduleResetQ, .divTick, .timerTickQ, .sysTimerResetQ, .sysTimerRunQ, .sysClkEnQ,
  .regfilePulseDelayQ, .captureDelayQ);

// file: bench/ccr_top_bench.sv
// self-checking bench for the clock and reset controller
`timescale 1ns/1ps
module ccr_top_bench;
  import ccr_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [8:0] regAddr = 9'h000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  ccr_word_t regWdata = 16'h0000;
  logic crystalTick = 1'b0;
  logic pllTick = 1'b0;
  logic pixelClkPin = 1'b0;
  logic [31:0] moduleIdle = 32'h00000000;
  ccr_word_t regRdataQ;
  logic [13:0] moduleResetQ;
  logic [31:0] moduleClkEnQ;
  logic [12:0] divTick;
  logic timerTickQ, sysTimerResetQ, sysTimerRunQ, sysClkEnQ, captureClkQ;
  logic [3:0] regfilePulseDelayQ;
  logic [15:0] captureDelayQ;
  int mismatches = 0;
  int checked = 0;
  // register map and implemented bits, reserved bits read back as 0
  logic [8:0] adr [17] = '{9'h012, 9'h014, 9'h016, 9'h018, 9'h01a, 9'h01c, 9'h01e, 9'h024, 9'h026,
    9'h030, 9'h032, 9'h034, 9'h036, 9'h038, 9'h03a, 9'h03c, 9'h03e};
  ccr_word_t msk [17] = '{16'h300f, 16'h10ff, 16'h100f, 16'h33ff, 16'h100f, 16'h303f, 16'h303f, 16'h3fff,
    16'h13ef, 16'h7fff, 16'h7f1f, 16'hf3ff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hf800};
  // soft reset slot order; rstHigh marks resets sitting at bit 13
  logic [8:0] rstAdr [14] = '{9'h012, 9'h012, 9'h014, 9'h016, 9'h018, 9'h018, 9'h01a, 9'h01c, 9'h01c,
    9'h01e, 9'h01e, 9'h024, 9'h024, 9'h026};
  logic [13:0] rstHigh = 14'h0a91;

  ccr_top uut (.sys_clk, .rst_b, .regAddr, .regWrite, .regRead, .regWdata, .regRdataQ, .crystalTick,
    .pllTick, .pixelClkPin, .moduleIdle, .moduleResetQ, .moduleClkEnQ, .divTick, .timerTickQ,
    .sysTimerResetQ, .sysTimerRunQ, .sysClkEnQ, .captureClkQ, .regfilePulseDelayQ, .captureDelayQ);

  // 125 MHz clock
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  // outputs are read right after an edge, so they show the previous edge
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // one write pulse, then two edges so register-driven outputs are settled
  task automatic wr(input logic [8:0] a, input ccr_word_t d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [8:0] a, input ccr_word_t e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(posedge sys_clk);
    chk("read data", regRdataQ, e);
    @(posedge sys_clk);
    chk("read idle", regRdataQ, 16'h0000);
  endtask
  task automatic pulse(input logic c, input logic p, input logic e);
    crystalTick <= c;
    pllTick <= p;
    @(posedge sys_clk);
    crystalTick <= 1'b0;
    pllTick <= 1'b0;
    @(posedge sys_clk);
    chk("timer tick", timerTickQ, e);
    @(posedge sys_clk);
    chk("timer tick end", timerTickQ, 1'b0);
  endtask
  // steady source for 24 cycles, ticks of every slot counted over the last 12, one nibble per slot
  task automatic cnt(input logic c, input logic p, input logic [51:0] e);
    logic [51:0] n;
    n = '0;
    crystalTick <= c;
    pllTick <= p;
    for (int i = 0; i < 24; i++) begin
      @(posedge sys_clk);
      if (i >= 12) begin
        for (int j = 0; j < 13; j++) n[4*j +: 4] += {3'h0, divTick[j]};
      end
    end
    crystalTick <= 1'b0;
    pllTick <= 1'b0;
    chk("divider ticks", n, e);
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("after reset", {sysTimerResetQ, sysTimerRunQ, sysClkEnQ, regfilePulseDelayQ}, 7'h38);
    // reset values, then all ones and all zeros through every register
    for (int i = 0; i < 17; i++) begin
      rd(adr[i], adr[i] == 9'h030 ? 16'h1801 : adr[i] == 9'h034 ? 16'h8000 : 16'h0000);
      wr(adr[i], 16'hffff);
      rd(adr[i], msk[i]);
      wr(adr[i], 16'h0000);
      rd(adr[i], 16'h0000);
    end
    wr(9'h020, 16'hffff);
    rd(9'h020, 16'h0000);
    // each soft reset alone on its own slot
    for (int i = 0; i < 14; i++) begin
      wr(rstAdr[i], rstHigh[i] ? 16'h2000 : 16'h1000);
      chk("soft reset", moduleResetQ, 14'h0001 << i);
      wr(rstAdr[i], 16'h0000);
    end
    // run bits alone ignore idle; with gating only the ungated clocks survive
    moduleIdle <= 32'hffffffff;
    for (int i = 0; i < 9; i++) wr(adr[i], msk[i] & 16'h0aaa);
    chk("run bits", moduleClkEnQ, 32'hffffffff);
    for (int i = 0; i < 9; i++) wr(adr[i], msk[i]);
    chk("gated idle", moduleClkEnQ, 32'h20000410);
    moduleIdle <= 32'h00000000;
    repeat (2) @(posedge sys_clk);
    chk("busy run", moduleClkEnQ, 32'hffffffff);
    for (int i = 0; i < 9; i++) wr(adr[i], 16'h0000);
    chk("all stopped", moduleClkEnQ, 32'h00000000);
    // timer clock source and enable
    wr(9'h026, 16'h0020);
    pulse(1'b1, 1'b0, 1'b1);
    pulse(1'b0, 1'b1, 1'b0);
    wr(9'h030, 16'h4000);
    pulse(1'b1, 1'b0, 1'b0);
    pulse(1'b0, 1'b1, 1'b1);
    wr(9'h026, 16'h0000);
    pulse(1'b0, 1'b1, 1'b0);
    // dividers /3 /6 /4 /6 /4 /3 on slots 3 6 9 10 11 12, bus /1 on slot 4
    wr(9'h034, 16'h8008);
    wr(9'h036, 16'h0005);
    wr(9'h032, 16'h0317);
    wr(9'h03c, 16'h3005);
    wr(9'h03e, 16'h1000);
    wr(9'h030, 16'h1809);
    cnt(1'b0, 1'b1, 52'h43230020c4000);
    wr(9'h030, 16'h1c09);
    cnt(1'b0, 1'b1, 52'h0000000000000);
    cnt(1'b1, 1'b0, 52'h43230020c4000);
    // capture source codes; sensor level stays low with its divider off
    for (int k = 0; k < 4; k++) begin
      wr(9'h030, 16'(k) << 8);
      for (int l = 0; l < 2; l++) begin
        pixelClkPin <= l[0];
        repeat (8) @(posedge sys_clk);
        chk("capture clock", captureClkQ, k[1] ? k[0] : l[0] ^ k[0]);
      end
    end
    // remaining slots /4 /2 /3 /3 /4 /3 /6 on 0 1 2 4 5 7 8, ratios set while disabled
    wr(9'h032, 16'h0000);
    wr(9'h034, 16'h8362);
    wr(9'h036, 16'h0300);
    wr(9'h038, 16'h0205);
    wr(9'h030, 16'h08f6);
    cnt(1'b0, 1'b1, 52'h0000240340463);
    wr(9'h030, 16'h3800);
    chk("timer held", {sysTimerResetQ, sysTimerRunQ, sysClkEnQ}, 3'b101);
    wr(9'h030, 16'h1000);
    chk("timer runs", {sysTimerResetQ, sysTimerRunQ, sysClkEnQ}, 3'b010);
    wr(9'h034, 16'hf000);
    chk("regfile delay", regfilePulseDelayQ, 4'hf);
    wr(9'h03a, 16'h4c21);
    chk("capture delay", captureDelayQ, 16'h4c21);
    wrap_up;
  end

  // hang guard, well past the seven hundred or so cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    wrap_up;
  end
endmodule
